//--- verilog/ampblk_defs.svh
// constants for the amplifier block configuration registers
// Function
// - Top bit 31 gates power, drivers and pump of both opamps
// - Control bits 1:0 set power level
// - Control bit 2 selects output driver
// - Never both output drivers active together
// - Control bit 11 enables charge pump
// - Compensation bits 1:0 select level
// - Set switch bit closes its switch
// - Clear alias ones open matching switches
// - Switch bit 21 permits cross-driver routing
// - Opamp zero plus inputs bits 0,2,3
// - Opamp one plus inputs bits 0,1,4
// - Bit 8 pin, bit 14 feedback minus
// - Switch bit 18 drives each opamp's own converter bus request
`ifndef AMPBLK_DEFS_SVH
`define AMPBLK_DEFS_SVH
`define AMPBLK_ADDR_W 4
`define AMPBLK_OFS_TOP 4'h0
`define AMPBLK_OFS_CTRL0 4'h1
`define AMPBLK_OFS_CTRL1 4'h2
`define AMPBLK_OFS_COMP0 4'h3
`define AMPBLK_OFS_COMP1 4'h4
`define AMPBLK_OFS_SW0 4'h5
`define AMPBLK_OFS_SW1 4'h6
`define AMPBLK_OFS_CLR0 4'h7
`define AMPBLK_OFS_CLR1 4'h8
`define AMPBLK_BIT_ENABLE 31
`define AMPBLK_BIT_DRIVE 2
`define AMPBLK_BIT_PUMP 11
`define AMPBLK_BIT_XROUTE 21
`define AMPBLK_BIT_OBUS 18
`define AMPBLK_BIT_NEG_PIN 8
`define AMPBLK_BIT_NEG_FB 14
`define AMPBLK_BIT_P0_BUS 0
`define AMPBLK_BIT_P0_PIN_A 2
`define AMPBLK_BIT_P0_PIN_B 3
`define AMPBLK_BIT_P1_BUS 0
`define AMPBLK_BIT_P1_PIN_A 1
`define AMPBLK_BIT_P1_PIN_B 4
`define AMPBLK_CTRL_MASK 32'h0000_0807
`define AMPBLK_TOP_MASK 32'h8000_0000
`define AMPBLK_COMP_MASK 32'h0000_0003
`define AMPBLK_ZERO 32'h0000_0000
`define AMPBLK_PWR_OFF 2'h0
`endif

//--- verilog/ampblk_pkg.sv
// types for the amplifier block configuration registers
package ampblk_pkg;
    typedef enum logic [1:0] {
        AMPBLK_PWR_OFF_E = 2'b00,
        AMPBLK_PWR_LOW_E = 2'b01,
        AMPBLK_PWR_MED_E = 2'b10,
        AMPBLK_PWR_HIGH_E = 2'b11
    } ampblk_power_t;

    typedef struct packed {
        logic enable;
        logic charge_pump_on;
        ampblk_power_t power_level;
        logic low_drive_on;
        logic high_drive_on;
        logic [1:0] compensation_level;
        logic cross_route_ok;
        logic pos_bus;
        logic pos_pin_a;
        logic pos_pin_b;
        logic neg_pin;
        logic neg_feedback;
        logic conv_bus_request;
        logic [31:0] switches;
    } ampblk_opamp_t;

    typedef struct packed {
        logic [31:0] top;
        logic [31:0] ctrl0;
        logic [31:0] ctrl1;
        logic [31:0] comp0;
        logic [31:0] comp1;
        logic [31:0] sw0;
        logic [31:0] sw1;
        logic [31:0] rdata;
    } ampblk_state_t;
endpackage

//--- verilog/ampblk_regs.sv
// register bank and analog control decode for the dual opamp block
//
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/1ns
`include "ampblk_defs.svh"
module ampblk_regs
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [`AMPBLK_ADDR_W-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    output ampblk_pkg::ampblk_opamp_t opamp0,
    output ampblk_pkg::ampblk_opamp_t opamp1
);
    ampblk_pkg::ampblk_state_t st;
    ampblk_pkg::ampblk_state_t next_st;

    // analog view of one opamp from its registers
    function automatic ampblk_pkg::ampblk_opamp_t decode(
        input logic [31:0] top,
        input logic [31:0] ctrl,
        input logic [31:0] comp,
        input logic [31:0] sw,
        input logic is_one
    );
        ampblk_pkg::ampblk_opamp_t o;
        logic en;
        logic live;
        en = top[`AMPBLK_BIT_ENABLE];
        live = en && (ctrl[1:0] != `AMPBLK_PWR_OFF);
        o.enable = en;
        o.power_level = en ? ampblk_pkg::ampblk_power_t'(ctrl[1:0])
            : ampblk_pkg::AMPBLK_PWR_OFF_E;
        o.charge_pump_on = en && ctrl[`AMPBLK_BIT_PUMP];
        // one select bit feeds both enables, so overlap is impossible
        o.high_drive_on = live && ctrl[`AMPBLK_BIT_DRIVE];
        o.low_drive_on = live && !ctrl[`AMPBLK_BIT_DRIVE];
        o.compensation_level = comp[1:0];
        o.cross_route_ok = sw[`AMPBLK_BIT_XROUTE];
        // switches follow the stored bits directly
        o.switches = sw;
        if (is_one)
        begin
            o.pos_bus = sw[`AMPBLK_BIT_P1_BUS];
            o.pos_pin_a = sw[`AMPBLK_BIT_P1_PIN_A];
            o.pos_pin_b = sw[`AMPBLK_BIT_P1_PIN_B];
        end
        else
        begin
            o.pos_bus = sw[`AMPBLK_BIT_P0_BUS];
            o.pos_pin_a = sw[`AMPBLK_BIT_P0_PIN_A];
            o.pos_pin_b = sw[`AMPBLK_BIT_P0_PIN_B];
        end
        o.neg_pin = sw[`AMPBLK_BIT_NEG_PIN];
        o.neg_feedback = sw[`AMPBLK_BIT_NEG_FB];
        // only a request: the converter side must also agree
        o.conv_bus_request = sw[`AMPBLK_BIT_OBUS];
        return o;
    endfunction

    always_comb
    begin
        next_st = st;
        next_st.rdata = `AMPBLK_ZERO;
        if (wr)
        begin
            if (addr == `AMPBLK_OFS_TOP)
                next_st.top = wdata & `AMPBLK_TOP_MASK;
            else if (addr == `AMPBLK_OFS_CTRL0)
                next_st.ctrl0 = wdata & `AMPBLK_CTRL_MASK;
            else if (addr == `AMPBLK_OFS_CTRL1)
                next_st.ctrl1 = wdata & `AMPBLK_CTRL_MASK;
            else if (addr == `AMPBLK_OFS_COMP0)
                next_st.comp0 = wdata & `AMPBLK_COMP_MASK;
            else if (addr == `AMPBLK_OFS_COMP1)
                next_st.comp1 = wdata & `AMPBLK_COMP_MASK;
            else if (addr == `AMPBLK_OFS_SW0)
                next_st.sw0 = wdata;
            else if (addr == `AMPBLK_OFS_SW1)
                next_st.sw1 = wdata;
            else if (addr == `AMPBLK_OFS_CLR0)
                next_st.sw0 = st.sw0 & ~wdata;
            else if (addr == `AMPBLK_OFS_CLR1)
                next_st.sw1 = st.sw1 & ~wdata;
        end
        if (rd)
        begin
            if (addr == `AMPBLK_OFS_TOP)
                next_st.rdata = st.top;
            else if (addr == `AMPBLK_OFS_CTRL0)
                next_st.rdata = st.ctrl0;
            else if (addr == `AMPBLK_OFS_CTRL1)
                next_st.rdata = st.ctrl1;
            else if (addr == `AMPBLK_OFS_COMP0)
                next_st.rdata = st.comp0;
            else if (addr == `AMPBLK_OFS_COMP1)
                next_st.rdata = st.comp1;
            else if (addr == `AMPBLK_OFS_SW0)
                next_st.rdata = st.sw0;
            else if (addr == `AMPBLK_OFS_SW1)
                next_st.rdata = st.sw1;
            else
                next_st.rdata = `AMPBLK_ZERO;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign rdata = st.rdata;
    assign opamp0 = decode(st.top, st.ctrl0, st.comp0, st.sw0, 1'b0);
    assign opamp1 = decode(st.top, st.ctrl1, st.comp1, st.sw1, 1'b1);
endmodule

//--- verif/ampblk_properties.sv
// port checks for the amplifier block registers
`timescale 1ns/1ns
module ampblk_properties
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire ampblk_pkg::ampblk_opamp_t opamp0,
    input wire ampblk_pkg::ampblk_opamp_t opamp1
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    AST_EN: assert property (wr && addr == 4'h0 |=>
        opamp1.enable == $past(wdata[31])) else $error("enable");
    AST_PWR: assert property (wr && addr == 4'h1 && opamp0.enable |=>
        opamp0.power_level == $past(wdata[1:0])) else $error("power");
    AST_DRV: assert property (wr && addr == 4'h1 && wdata[1:0] != 2'h0
        && opamp0.enable |=> opamp0.high_drive_on == $past(wdata[2]))
        else $error("drive");
    AST_EXCL: assert property (
        !(opamp0.low_drive_on && opamp0.high_drive_on)) else $error("excl");
    AST_PUMP: assert property (wr && addr == 4'h2 && opamp1.enable |=>
        opamp1.charge_pump_on == $past(wdata[11])) else $error("pump");
    AST_COMP: assert property (wr && addr == 4'h4 |=>
        opamp1.compensation_level == $past(wdata[1:0])) else $error("comp");
    AST_SET: assert property (wr && addr == 4'h5 |=>
        opamp0.switches == $past(wdata)) else $error("set");
    AST_CLR: assert property (wr && addr == 4'h8 |=>
        opamp1.switches == ($past(opamp1.switches) & ~$past(wdata)))
        else $error("clear");
endmodule
bind ampblk_regs ampblk_properties u (.clk, .sys_rst, .addr, .wdata, .wr,
    .opamp0, .opamp1);

//--- verif/testbench.sv
// bench for the amplifier block registers
`timescale 1ns/1ns
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
    n_fail++; $display("BAD %0t %h %h", $time, g, e); end end
module testbench;
    typedef struct {logic [3:0] a; logic [31:0] w, e;} ampblk_row_t;
    logic clk = 1'h0, sys_rst = 1'h1, wr = 1'h0, rd = 1'h0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata, q;
    ampblk_pkg::ampblk_opamp_t opamp0, opamp1;
    int n_fail = 0, samples_checked = 0;
    // switch words close at most one switch per input path
    ampblk_row_t rows [9] = '{'{4'h0,32'hFFFFFFFF,32'h80000000},
    '{4'h1,32'hFFFFFFFF,32'h807},'{4'h2,32'h802,32'h802},
    '{4'h3,32'h2,32'h2},'{4'h4,32'hFFFFFFFF,32'h3},
    '{4'h5,32'h240108,32'h240108},'{4'h6,32'h204002,32'h204002},
    '{4'h7,32'h9,32'h0},'{4'h9,32'h12345678,32'h0}};
    ampblk_regs dut (.clk, .sys_rst, .addr, .wdata, .wr, .rd, .rdata,
        .opamp0, .opamp1);
    initial forever #20 clk = ~clk;
    // one strobe per call; the gap edge keeps strobes single-cycle
    task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        {wr, rd} <= 2'h0;
        #1 q = rdata;
    endtask
    task automatic print_verdict;
        $display("bad %0d of %0d", n_fail, samples_checked);
        if (n_fail == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        repeat (12) @(posedge clk);
        sys_rst <= 1'h0;
        foreach (rows[i])
        begin
            acc(1'h1, rows[i].a, rows[i].w);
            acc(1'h0, rows[i].a, 32'h0);
            `CHK(q, rows[i].e)
        end
        `CHK({opamp1.low_drive_on, opamp1.power_level}, 3'h6)
        `CHK({opamp0.pos_pin_b, opamp0.neg_pin}, 2'h1)
        `CHK({opamp0.conv_bus_request, opamp0.compensation_level}, 3'h6)
        acc(1'h1, 4'h8, 32'h0);
        `CHK(opamp1.switches, 32'h00204002)
        acc(1'h1, 4'h8, 32'hFFFF0000);
        `CHK({opamp1.pos_pin_a, opamp1.cross_route_ok, opamp1.neg_feedback}, 3'h5)
        @(posedge clk) sys_rst <= 1'h1;
        @(posedge clk) sys_rst <= 1'h0;
        #1 `CHK(opamp1.switches, 32'h0)
        `CHK({opamp0.enable, opamp0.power_level}, 3'h0)
        print_verdict;
    end
endmodule
